// ### design/pus_pkg.sv
// Constants, encodings and timing for the power-up serial report block.
// Assumes a single 40 MHz clock; every cycle count here is derived from that rate.
`default_nettype none

package pus_pkg;

  localparam int          CLK_HZ        = 40_000_000;
  localparam int          BAUD          = 1200;
  localparam int          BIT_CYC       = CLK_HZ / BAUD;
  localparam int          PWRUP_MAX_MS  = 100;
  localparam int          PWRUP_CYC     = (CLK_HZ / 1000) * PWRUP_MAX_MS;
  localparam int          GAP_US        = 1000;
  localparam int          GAP_CYC       = (CLK_HZ / 1_000_000) * GAP_US;

  localparam int          DIEL_SCALE    = 50;
  localparam int          DIEL_FRAC     = 8;
  localparam int          TEMP_OFS      = 400;
  localparam int          TEMP_KNEE     = 900;
  localparam int          TEMP_CMP      = 5;
  localparam int          CKS_BITS      = 6;
  localparam logic [7:0]  CKS_OFS       = 8'h20;
  localparam int          FW_QUIET_REV  = 329;
  localparam int          NUM_DIGITS    = 5;

  localparam logic [7:0]  CHR_CR        = 8'h0D;
  localparam logic [7:0]  CHR_LF        = 8'h0A;
  localparam logic [7:0]  CHR_SP        = 8'h20;
  localparam logic [7:0]  CHR_ZERO      = 8'h30;
  localparam logic [7:0]  CHR_QUERY     = 8'h3F;
  localparam logic [7:0]  CHR_BANG      = 8'h21;
  localparam logic [7:0]  ADDR_ZERO     = 8'h30;
  // Arbitrary neutral sensor type code.
  localparam logic [7:0]  TYPE_CHAR_DEF = 8'h61;

  typedef enum logic [2:0] {
    ST_MEAS  = 3'h0,
    ST_ANNC  = 3'h1,
    ST_SEND  = 3'h2,
    ST_SDI   = 3'h3,
    ST_REPLY = 3'h4
  } pus_state_type;

  typedef enum logic [3:0] {
    SEC_DIEL = 4'h0,
    SEC_SP1  = 4'h1,
    SEC_PH   = 4'h2,
    SEC_SP2  = 4'h3,
    SEC_TEMP = 4'h4,
    SEC_CR1  = 4'h5,
    SEC_TYPE = 4'h6,
    SEC_CKS  = 4'h7,
    SEC_CR2  = 4'h8,
    SEC_LF   = 4'h9,
    SEC_DONE = 4'hA
  } pus_sec_type;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'h0,
    TX_START = 2'h1,
    TX_DATA  = 2'h2,
    TX_STOP  = 2'h3
  } pus_tx_state_type;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'h0,
    RX_START = 2'h1,
    RX_DATA  = 2'h2,
    RX_STOP  = 2'h3
  } pus_rx_state_type;

endpackage

`default_nettype wire

// ### design/pus_tx_if.sv
// Character hand-off between the report sequencer and the serial transmitter.
// Assumes both ends sit on the same clock.
`timescale 1ns/100ps
`default_nettype none

interface pus_tx_if;
  logic       valid;
  logic       ready;
  logic [7:0] data;
  logic       line;

  modport src (output valid, output data, input ready, input line);
  modport tx  (input valid, input data, output ready, output line);
endinterface

`default_nettype wire

// ### design/pus_uart_tx.sv
// Eight-bit serial transmitter with one start and one stop bit.
// Assumes the caller holds valid and data until ready is seen high.
`timescale 1ns/100ps
`default_nettype none

module pus_uart_tx
  import pus_pkg::*;
#(
  parameter int BIT_CYC_P = BIT_CYC
) (
  input  wire logic i_clk,
  input  wire logic i_nrst,
  input  wire logic i_ce,
  pus_tx_if.tx      tx
);

  pus_tx_state_type state;
  pus_tx_state_type next_state;
  logic [15:0]      cnt;
  logic [15:0]      next_cnt;
  logic [2:0]       bit_idx;
  logic [2:0]       next_bit_idx;
  logic [7:0]       shreg;
  logic [7:0]       next_shreg;
  logic             line;
  logic             next_line;

  assign tx.ready = (state == TX_IDLE);
  assign tx.line  = line;

  // Frame sequencing; the line rests high whenever no frame is running.
  always_comb begin
    next_state   = state;
    next_cnt     = cnt;
    next_bit_idx = bit_idx;
    next_shreg   = shreg;
    next_line    = line;
    case (state)
      TX_IDLE: begin
        next_line = 1'b1;
        if (tx.valid) begin
          next_shreg = tx.data;
          next_line  = 1'b0;
          next_cnt   = 16'(BIT_CYC_P - 1);
          next_state = TX_START;
        end
      end
      TX_START: begin
        if (cnt == 16'h0000) begin
          next_line    = shreg[0];
          next_cnt     = 16'(BIT_CYC_P - 1);
          next_bit_idx = 3'h0;
          next_state   = TX_DATA;
        end else begin
          next_cnt = cnt - 16'h0001;
        end
      end
      TX_DATA: begin
        if (cnt == 16'h0000) begin
          next_cnt = 16'(BIT_CYC_P - 1);
          if (bit_idx == 3'h7) begin
            next_line  = 1'b1;
            next_state = TX_STOP;
          end else begin
            next_bit_idx = bit_idx + 3'h1;
            next_line    = shreg[next_bit_idx];
          end
        end else begin
          next_cnt = cnt - 16'h0001;
        end
      end
      TX_STOP: begin
        if (cnt == 16'h0000) begin
          next_state = TX_IDLE;
        end else begin
          next_cnt = cnt - 16'h0001;
        end
      end
      default: begin
        next_state = TX_IDLE;
        next_line  = 1'b1;
      end
    endcase
  end

  // State registers.
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      state   <= TX_IDLE;
      cnt     <= 16'h0000;
      bit_idx <= 3'h0;
      shreg   <= 8'h00;
      line    <= 1'b1;
    end else if (i_ce) begin
      state   <= next_state;
      cnt     <= next_cnt;
      bit_idx <= next_bit_idx;
      shreg   <= next_shreg;
      line    <= next_line;
    end
  end

endmodule // pus_uart_tx

`default_nettype wire

// ### design/pus_top.sv
// Power-up report sequencer: measure, announce and send one report unless quiet, then listen.
// Assumes power cycling drives i_nrst and measurement logic shares i_clk.
`timescale 1ns/100ps
`default_nettype none

module pus_top
  import pus_pkg::*;
#(
  parameter int         BIT_CYC_P   = BIT_CYC,
  parameter int         PWRUP_CYC_P = PWRUP_CYC,
  parameter int         GAP_CYC_P   = GAP_CYC,
  parameter int         FW_REV      = 329,
  parameter logic [7:0] TYPE_CHAR   = TYPE_CHAR_DEF
) (
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_ce,
  input  wire logic        i_meas_valid,
  input  wire logic [15:0] i_diel_q8,
  input  wire logic [11:0] i_temp_dc,
  input  wire logic [7:0]  i_addr,
  input  wire logic        i_line,
  output logic             o_line,
  output logic             o_line_oe_n,
  output logic             o_sdi_mode
);

  pus_tx_if txi ();

  pus_uart_tx #(
    .BIT_CYC_P (BIT_CYC_P)
  ) u_tx (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_ce   (i_ce),
    .tx     (txi.tx)
  );

  // Converts a binary value to five packed decimal digits.
  function automatic logic [19:0] to_bcd(input logic [15:0] val);
    logic [19:0] bcd;
    bcd = 20'h00000;
    for (int i = 15; i >= 0; i--) begin
      for (int d = 0; d < NUM_DIGITS; d++) begin
        if (bcd[d*4 +: 4] > 4'h4) begin
          bcd[d*4 +: 4] = bcd[d*4 +: 4] + 4'h3;
        end
      end
      bcd = {bcd[18:0], val[i]};
    end
    return bcd;
  endfunction

  // Index of the most significant non-zero digit, zero for a value of zero.
  function automatic logic [2:0] lead_digit(input logic [19:0] bcd);
    logic [2:0] idx;
    idx = 3'h0;
    for (int d = 0; d < NUM_DIGITS; d++) begin
      if (bcd[d*4 +: 4] != 4'h0) begin
        idx = 3'(d);
      end
    end
    return idx;
  endfunction

  // Two-flop synchroniser for the shared data line.
  logic line_s1;
  logic line_s2;

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      line_s1 <= 1'b1;
      line_s2 <= 1'b1;
    end else if (i_ce) begin
      line_s1 <= i_line;
      line_s2 <= line_s1;
    end
  end

  // Main sequencer state.
  pus_state_type state;
  pus_state_type next_state;
  logic [23:0]   tmr;
  logic [23:0]   next_tmr;
  logic          have_meas;
  logic          next_have_meas;
  logic [15:0]   diel_q8;
  logic [15:0]   next_diel_q8;
  logic [11:0]   temp_dc;
  logic [11:0]   next_temp_dc;
  logic [7:0]    addr;
  logic [7:0]    next_addr;
  pus_sec_type   sec;
  pus_sec_type   next_sec;
  logic [2:0]    dig;
  logic [2:0]    next_dig;
  logic [CKS_BITS-1:0] cks;
  logic [CKS_BITS-1:0] next_cks;
  logic          next_line;
  logic          next_line_oe_n;
  logic          next_sdi_mode;
  logic          query_hit;

  // Field values derived from the latched measurement.
  logic [21:0]        diel_prod;
  logic [15:0]        diel_raw;
  logic signed [13:0] temp_sum;
  logic [15:0]        temp_lin;
  logic [15:0]        temp_raw;
  logic [19:0]        diel_bcd;
  logic [19:0]        temp_bcd;
  logic [7:0]         cur_char;
  logic               quiet;

  // Scale and compress the readings, then split into decimal digits.
  always_comb begin
    diel_prod = 22'(diel_q8) * 22'(DIEL_SCALE);
    diel_raw  = 16'(diel_prod >> DIEL_FRAC);
    temp_sum  = 14'($signed(i_temp_sign_ext(temp_dc))) + 14'(TEMP_OFS);
    temp_lin  = temp_sum[13] ? 16'h0000 : 16'(temp_sum);
    if (temp_lin > 16'(TEMP_KNEE)) begin
      temp_raw = 16'(TEMP_KNEE) + 16'((temp_lin - 16'(TEMP_KNEE)) / 16'(TEMP_CMP));
    end else begin
      temp_raw = temp_lin;
    end
    diel_bcd = to_bcd(diel_raw);
    temp_bcd = to_bcd(temp_raw);
    quiet    = (FW_REV >= FW_QUIET_REV) && (addr != ADDR_ZERO);
  end

  // Sign extension helper for the decicelsius reading.
  function automatic logic [13:0] i_temp_sign_ext(input logic [11:0] v);
    return {{2{v[11]}}, v};
  endfunction

  // Character offered to the transmitter for the current report section.
  always_comb begin
    case (sec)
      SEC_DIEL: cur_char = CHR_ZERO | {4'h0, diel_bcd[dig*4 +: 4]};
      SEC_SP1:  cur_char = CHR_SP;
      SEC_PH:   cur_char = CHR_ZERO;
      SEC_SP2:  cur_char = CHR_SP;
      SEC_TEMP: cur_char = CHR_ZERO | {4'h0, temp_bcd[dig*4 +: 4]};
      SEC_CR1:  cur_char = CHR_CR;
      SEC_TYPE: cur_char = TYPE_CHAR;
      SEC_CKS:  cur_char = {2'b00, cks} + CKS_OFS;
      SEC_CR2:  cur_char = CHR_CR;
      SEC_LF:   cur_char = CHR_LF;
      default:  cur_char = CHR_LF;
    endcase
  end

  assign txi.data  = (state == ST_REPLY) ? addr : cur_char;
  assign txi.valid = ((state == ST_SEND) && (sec != SEC_DONE)) ||
                     ((state == ST_REPLY) && (sec == SEC_CR2));

  // Sequencer next state. Reply mode reuses sec: SEC_CR2 means the address
  // character is still to be queued, SEC_DONE means it has been taken.
  always_comb begin
    next_state     = state;
    next_tmr       = tmr;
    next_have_meas = have_meas;
    next_diel_q8   = diel_q8;
    next_temp_dc   = temp_dc;
    next_addr      = addr;
    next_sec       = sec;
    next_dig       = dig;
    next_cks       = cks;
    next_line      = o_line;
    next_line_oe_n = o_line_oe_n;
    next_sdi_mode  = o_sdi_mode;
    if ((state == ST_MEAS || state == ST_ANNC) && i_meas_valid) begin
      next_have_meas = 1'b1;
      next_diel_q8   = i_diel_q8;
      next_temp_dc   = i_temp_dc;
    end
    case (state)
      ST_MEAS: begin
        next_addr      = i_addr;
        next_line      = 1'b0;
        next_line_oe_n = 1'b0;
        next_tmr       = tmr + 24'h000001;
        if (quiet && (have_meas || i_meas_valid)) begin
          next_line_oe_n = 1'b1;
          next_sdi_mode  = 1'b1;
          next_state     = ST_SDI;
        end else if (!quiet && (have_meas || tmr >= 24'(PWRUP_CYC_P - 2))) begin
          next_line  = 1'b1;
          next_tmr   = 24'h000000;
          next_state = ST_ANNC;
        end
      end
      ST_ANNC: begin
        next_line = 1'b1;
        if (tmr < 24'(GAP_CYC_P - 1)) begin
          next_tmr = tmr + 24'h000001;
        end else if (have_meas) begin
          next_sec   = SEC_DIEL;
          next_dig   = lead_digit(diel_bcd);
          next_cks   = '0;
          next_state = ST_SEND;
        end
      end
      ST_SEND: begin
        next_line = txi.line;
        if (txi.valid && txi.ready) begin
          if (sec <= SEC_TYPE) begin
            next_cks = cks + cur_char[CKS_BITS-1:0];
          end
          case (sec)
            SEC_DIEL: if (dig == 3'h0) next_sec = SEC_SP1; else next_dig = dig - 3'h1;
            SEC_TEMP: if (dig == 3'h0) next_sec = SEC_CR1; else next_dig = dig - 3'h1;
            SEC_SP2: begin
              next_sec = SEC_TEMP;
              next_dig = lead_digit(temp_bcd);
            end
            default: next_sec = pus_sec_type'(sec + 4'h1);
          endcase
        end else if (sec == SEC_DONE && txi.ready) begin
          next_line_oe_n = 1'b1;
          next_sdi_mode  = 1'b1;
          next_state     = ST_SDI;
        end
      end
      ST_SDI: begin
        next_line      = 1'b1;
        next_line_oe_n = 1'b1;
        if (query_hit) begin
          next_sec       = SEC_CR2;
          next_line_oe_n = 1'b0;
          next_state     = ST_REPLY;
        end
      end
      ST_REPLY: begin
        next_line = txi.line;
        if (txi.valid && txi.ready) begin
          next_sec = SEC_DONE;
        end else if (sec == SEC_DONE && txi.ready) begin
          next_line_oe_n = 1'b1;
          next_state     = ST_SDI;
        end
      end
      default: begin
        next_state = ST_MEAS;
      end
    endcase
  end

  // Sequencer registers; only a reset (power cycle) returns to measuring.
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      state       <= ST_MEAS;
      tmr         <= 24'h000000;
      have_meas   <= 1'b0;
      diel_q8     <= 16'h0000;
      temp_dc     <= 12'h000;
      addr        <= ADDR_ZERO;
      sec         <= SEC_DIEL;
      dig         <= 3'h0;
      cks         <= '0;
      o_line      <= 1'b0;
      o_line_oe_n <= 1'b0;
      o_sdi_mode  <= 1'b0;
    end else if (i_ce) begin
      state       <= next_state;
      tmr         <= next_tmr;
      have_meas   <= next_have_meas;
      diel_q8     <= next_diel_q8;
      temp_dc     <= next_temp_dc;
      addr        <= next_addr;
      sec         <= next_sec;
      dig         <= next_dig;
      cks         <= next_cks;
      o_line      <= next_line;
      o_line_oe_n <= next_line_oe_n;
      o_sdi_mode  <= next_sdi_mode;
    end
  end

  // Command receiver, alive only in command mode so the announce pulse and
  // our own report cannot be mistaken for a query.
  pus_rx_state_type rx_state;
  pus_rx_state_type next_rx_state;
  logic [15:0]      rx_cnt;
  logic [15:0]      next_rx_cnt;
  logic [2:0]       rx_bit;
  logic [2:0]       next_rx_bit;
  logic [7:0]       rx_sh;
  logic [7:0]       next_rx_sh;
  logic [7:0]       rx_prev;
  logic [7:0]       next_rx_prev;
  logic             next_query_hit;

  always_comb begin
    next_rx_state  = rx_state;
    next_rx_cnt    = rx_cnt;
    next_rx_bit    = rx_bit;
    next_rx_sh     = rx_sh;
    next_rx_prev   = rx_prev;
    next_query_hit = 1'b0;
    if (state != ST_SDI) begin
      next_rx_state = RX_IDLE;
      next_rx_prev  = 8'h00;
    end else begin
      case (rx_state)
        RX_IDLE: begin
          if (!line_s2) begin
            next_rx_cnt   = 16'(BIT_CYC_P / 2 - 1);
            next_rx_state = RX_START;
          end
        end
        RX_START: begin
          if (rx_cnt != 16'h0000) begin
            next_rx_cnt = rx_cnt - 16'h0001;
          end else if (line_s2) begin
            next_rx_state = RX_IDLE;                  // Glitch, not a start bit.
          end else begin
            next_rx_cnt   = 16'(BIT_CYC_P - 1);
            next_rx_bit   = 3'h0;
            next_rx_state = RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_cnt != 16'h0000) begin
            next_rx_cnt = rx_cnt - 16'h0001;
          end else begin
            next_rx_sh  = {line_s2, rx_sh[7:1]};
            next_rx_cnt = 16'(BIT_CYC_P - 1);
            next_rx_bit = rx_bit + 3'h1;
            if (rx_bit == 3'h7) begin
              next_rx_state = RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rx_cnt != 16'h0000) begin
            next_rx_cnt = rx_cnt - 16'h0001;
          end else begin
            next_rx_state = RX_IDLE;
            if (line_s2) begin
              next_rx_prev   = rx_sh;
              next_query_hit = (rx_prev == CHR_QUERY) && (rx_sh == CHR_BANG);
            end else begin
              next_rx_prev = 8'h00;                   // Framing error drops history.
            end
          end
        end
        default: next_rx_state = RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      rx_state  <= RX_IDLE;
      rx_cnt    <= 16'h0000;
      rx_bit    <= 3'h0;
      rx_sh     <= 8'h00;
      rx_prev   <= 8'h00;
      query_hit <= 1'b0;
    end else if (i_ce) begin
      rx_state  <= next_rx_state;
      rx_cnt    <= next_rx_cnt;
      rx_bit    <= next_rx_bit;
      rx_sh     <= next_rx_sh;
      rx_prev   <= next_rx_prev;
      query_hit <= next_query_hit;
    end
  end

endmodule // pus_top

`default_nettype wire

// ### design/pus_unused_placeholder_never.sv
`default_nettype none
`default_nettype wire

// ### verification/pus_top_assertions.sv
// Checker for the power-up report block, bound to every pus_top instance.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none

module pus_top_checker #(
  parameter int BIT_CYC_P   = 16,
  parameter int PWRUP_CYC_P = 200
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic o_line,
  input wire logic o_line_oe_n,
  input wire logic o_sdi_mode
);
  logic        ann;
  logic        line_q;
  logic        in_fr;
  int unsigned fc;
  int unsigned cyc;

  // A fall of the driven line after the raise opens a ten-bit frame; earlier edges are not framing.
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      ann    <= 1'b0;
      line_q <= 1'b0;
      in_fr  <= 1'b0;
      fc     <= 0;
      cyc    <= 0;
    end else begin
      ann    <= ann | o_line;
      line_q <= o_line;
      cyc    <= cyc + 1;
      if (in_fr) begin
        fc    <= fc + 1;
        in_fr <= (fc != 10 * BIT_CYC_P - 1);
      end else begin
        fc    <= 1;
        in_fr <= ann & line_q & ~o_line & ~o_line_oe_n;
      end
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);

  // The reply start bit must follow the grab of the line within a few cycles.
  sequence s_start_bit;
    ##[1:8] !o_line;
  endsequence

  // Line, frame and mode checks.
  a_reset_values: assert property ($rose(i_nrst) |-> !o_line && !o_line_oe_n && !o_sdi_mode)
    else $error("outputs not at reset values after release");
  a_announce_due: assert property (!ann && !o_line_oe_n |-> cyc < PWRUP_CYC_P + 4)
    else $error("line not raised in time");
  a_start_low: assert property (in_fr && fc < BIT_CYC_P |-> !o_line)
    else $error("start bit not low");
  a_bit_steady: assert property (in_fr && fc % BIT_CYC_P != 0 |-> $stable(o_line))
    else $error("line moved inside a bit time");
  a_stop_high: assert property (in_fr && fc >= 9 * BIT_CYC_P |-> o_line)
    else $error("stop bit not high");
  a_idle_high: assert property (ann && !in_fr && !o_line_oe_n && !o_line |-> line_q)
    else $error("line low between characters");
  a_sdi_entry: assert property ($rose(o_sdi_mode) |-> o_line_oe_n && !in_fr)
    else $error("command mode entered mid frame");
  a_sdi_sticky: assert property (o_sdi_mode |=> o_sdi_mode)
    else $error("command mode left without power cycle");
  a_reply_start: assert property (o_sdi_mode && $fell(o_line_oe_n) |-> s_start_bit)
    else $error("reply start bit missing");
endmodule // pus_top_checker

bind pus_top pus_top_checker #(.BIT_CYC_P(BIT_CYC_P), .PWRUP_CYC_P(PWRUP_CYC_P)) u_chk (
  .i_clk(i_clk), .i_nrst(i_nrst), .o_line(o_line), .o_line_oe_n(o_line_oe_n), .o_sdi_mode(o_sdi_mode));

`default_nettype wire

// ### verification/pus_logger_model.sv
// Behavioural data logger: decodes sensor frames and sends the address query.
// Assumes the bench resolves the shared line, with a pull-up, and feeds it back.
`timescale 1ns/100ps
`default_nettype none

module pus_logger_model #(
  parameter int BIT = 16
) (
  input  wire logic i_clk,
  input  wire logic i_pwr,
  input  wire logic i_line,
  input  wire logic i_query,
  output logic       o_drv_en,
  output logic       o_drv,
  output logic [7:0] o_byte,
  output logic       o_ferr,
  output int         o_cnt
);
  logic       prev;
  logic [7:0] q;

  // Receiver arms only on a fall from high, so the measuring low and the raise never decode.
  // It samples on the falling clock edge, well clear of the sensor's register updates.
  initial begin
    prev   = 1'b0;
    o_byte = 8'h00;
    o_ferr = 1'b0;
    o_cnt  = 0;
    forever begin
      @(negedge i_clk);
      if (prev && !i_line && !o_drv_en) begin
        repeat (BIT / 2) @(negedge i_clk);
        for (int i = 0; i < 8; i++) begin
          repeat (BIT) @(negedge i_clk);
          o_byte[i] = i_line;
        end
        repeat (BIT) @(negedge i_clk);
        o_ferr = o_ferr | !i_line;
        o_cnt  = o_cnt + 1;
      end
      prev = i_line && i_pwr;
    end
  end

  // Transmitter sends the query back to back; the bench wires one sensor only, since all would answer.
  // The last stop bit is left to the pull-up, because the sensor may start its reply before it ends.
  initial begin
    o_drv_en = 1'b0;
    o_drv    = 1'b1;
    forever begin
      @(posedge i_clk);
      if (i_query) begin
        for (int k = 0; k < 2; k++) begin
          q = k ? 8'h21 : 8'h3F;
          for (int j = 0; j < 10; j++) begin
            #2 o_drv = (j == 0) ? 1'b0 : (j == 9) ? 1'b1 : q[j-1];
            o_drv_en = (k == 0) || (j != 9);
            repeat (BIT) @(posedge i_clk);
          end
        end
        #2 o_drv_en = 1'b0;
      end
    end
  end
endmodule // pus_logger_model

`default_nettype wire

// ### verification/testbench.sv
// Bench: power cycles the block, reads each report through the logger model, queries the address.
// Assumes shortened bit, power-up and gap counts so a report takes a few thousand cycles.
`timescale 1ns/100ps
`default_nettype none

module testbench
  import pus_pkg::*;
;
  localparam int B = 16;
  logic        clk;
  logic        nrst;
  logic        meas;
  logic [15:0] diel;
  logic [11:0] temp;
  logic [7:0]  addr;
  logic        query;
  logic        line;
  logic        o_line;
  logic        oe_n;
  logic        sdi;
  logic        drv_en;
  logic        drv;
  logic [7:0]  rx_byte;
  logic        ferr;
  int          rx_cnt;
  int          failures;
  int          checks_done;

  // A released line floats up through the pull-up.
  assign line = !oe_n ? o_line : (drv_en ? drv : 1'b1);

  pus_top #(.BIT_CYC_P(B), .PWRUP_CYC_P(200), .GAP_CYC_P(20)) dut (
    .i_clk(clk), .i_nrst(nrst), .i_ce(1'b1), .i_meas_valid(meas), .i_diel_q8(diel), .i_temp_dc(temp),
    .i_addr(addr), .i_line(line), .o_line(o_line), .o_line_oe_n(oe_n), .o_sdi_mode(sdi));

  pus_logger_model #(.BIT(B)) u_log (.i_clk(clk), .i_pwr(nrst), .i_line(line), .i_query(query),
    .o_drv_en(drv_en), .o_drv(drv), .o_byte(rx_byte), .o_ferr(ferr), .o_cnt(rx_cnt));

  // Clock at 40 MHz.
  always #12.5 clk = ~clk;

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask

  // Inputs always move 2 ns after an edge, clear of the sampling instant.
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic power_cycle(input logic [7:0] a);
    nrst = 1'b0;
    addr = a;
    tick(3);
    nrst = 1'b1;
  endtask

  task automatic get_byte(output logic [7:0] b, input int lim);
    int n;
    n = rx_cnt;
    for (int k = 0; k < lim && rx_cnt == n; k++) tick(1);
    chk_bit(rx_cnt != n, 1'b1);
    b = rx_byte;
  endtask

  function automatic void put_dec(ref logic [7:0] s[$], input int v);
    if (v >= 10) put_dec(s, v / 10);
    s.push_back(8'h30 + 8'(v % 10));
  endfunction

  // One report after a power cycle; a late measurement shows the forced raise and the held send.
  task automatic t_report(input logic [15:0] q8, input logic [11:0] dc, input int wait_c);
    logic [7:0] exp[$];
    logic [7:0] b;
    int t;
    int sum;
    power_cycle(ADDR_ZERO);
    chk_bit(o_line | oe_n, 1'b0);
    tick(wait_c);
    chk_bit(o_line, wait_c > 210);
    diel = q8;
    temp = dc;
    meas = 1'b1;
    tick(1);
    meas = 1'b0;
    diel = ~q8;
    temp = ~dc;
    t = $signed(dc) + 400;
    if (t < 0) t = 0;
    if (t > 900) t = 900 + (t - 900) / 5;
    put_dec(exp, int'(q8) * 50 / 256);
    exp.push_back(CHR_SP);
    exp.push_back(CHR_ZERO);
    exp.push_back(CHR_SP);
    put_dec(exp, t);
    exp.push_back(CHR_CR);
    exp.push_back(TYPE_CHAR_DEF);
    sum = 0;
    foreach (exp[i]) sum += exp[i];
    exp.push_back(8'(sum % 64 + 32));
    exp.push_back(CHR_CR);
    exp.push_back(CHR_LF);
    foreach (exp[i]) begin
      get_byte(b, 40 * B + 400);
      chk_byte(b, exp[i]);
    end
    tick(B);
    chk_bit(sdi & oe_n & !ferr, 1'b1);
  endtask

  task automatic t_query(input logic [7:0] a);
    logic [7:0] b;
    query = 1'b1;
    tick(1);
    query = 1'b0;
    get_byte(b, 40 * B);
    chk_byte(b, a);
    tick(B);
    chk_bit(oe_n, 1'b1);
  endtask

  // A non-zero address keeps the block silent, yet it still answers the query.
  task automatic t_quiet();
    int n;
    power_cycle(8'h37);
    n = rx_cnt;
    meas = 1'b1;
    tick(1);
    meas = 1'b0;
    tick(400);
    chk_bit(rx_cnt == n && oe_n && sdi, 1'b1);
    t_query(8'h37);
  endtask

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    meas = 1'b0;
    diel = 16'h0000;
    temp = 12'h000;
    query = 1'b0;
    failures = 0;
    checks_done = 0;
    t_report(16'h0E00, 12'h0F5, 50);
    t_query(ADDR_ZERO);
    t_report(16'h0000, 12'h1F4, 300);
    t_report(16'hFFFF, 12'h258, 5);
    t_report(16'h0100, 12'hE70, 5);
    t_quiet();
    print_verdict();
  end

  // Watchdog: the run needs about 10500 cycles, so 60000 means a hang.
  initial begin
    #(25 * 60000);
    failures++;
    print_verdict();
  end
endmodule // testbench

`default_nettype wire
